// >>> ddr_mem_model.sv
module ddr_mem_model (
  input  wire logic clk,    // Reference clock.
  output logic      strobe  // Strobe toward the pin.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic released = 1'b1;
  logic drive_lvl = 1'b0;

  // A released line has no pull; it shows the inverse of the last driven level, so it reads high and only a driven burst reads low.
  assign strobe = released ? ~drive_lvl : drive_lvl;

  // Drives a preamble, then beats, then a long postamble before letting go.
  task automatic burst(input int pre, input int beats);
    @(posedge clk);
    released <= 1'b0;
    drive_lvl <= 1'b0;
    repeat (pre) @(posedge clk);
    for (int i = 0; i < beats; i++) begin
      drive_lvl <= ~i[0];
      @(posedge clk);
    end
    drive_lvl <= 1'b0;
    repeat (12) @(posedge clk);
    released <= 1'b1;
  endtask
endmodule

// >>> ddr_strobe_delay_calibration.sv
`include "ddr_strobe_regs.svh"

// Functional notes
// - A group spans sixteen or fourteen pins; the ninth carries the strobe.
// - Without memory the strobe pin is general I/O, still feeding the delay.
// - The calibrator derives a quarter-period delay code from its reference clock.
// - Update input low refreshes the output code; high holds it.
// - Lock shows the loop is in phase; reset returns it to start.
// - A sensitivity bit selects a strict or tolerant lock detector.
// - The buffer delays the strobe by the code for the capture registers.
// - The undelayed strobe is also passed to the fabric.
// - A preamble detect is derived from the incoming strobe.
// - Polarity is the clock level at the first preamble detect edge.
module ddr_strobe_delay_calibration #(
  parameter bit NARROW_GROUP = 1'b0                  // Selects the fourteen pin group variant.
) (
  input  wire logic        REF_CLK,                  // Reference clock, 10 MHz.
  input  wire logic        RST,                      // Synchronous reset, active high.
  input  wire logic        DELAY_UPDATE_N,           // Low lets the delay code refresh.
  input  wire logic        READ_PULSE,               // Read pulse from the fabric.
  input  wire logic        SYS_CLK_LVL,              // Fabric system clock level.
  input  wire logic        STROBE_I,                 // Strobe pin input.
  output logic             STROBE_O,                 // Strobe pin output in general I/O use.
  output logic             STROBE_OE,                // Strobe pin output enable.
  output logic             STROBE_DELAYED,           // Delayed strobe to the capture registers.
  output logic             STROBE_RAW,               // Undelayed strobe to the fabric.
  output logic             PREAMBLE_DET,             // Preamble detect to the fabric.
  output logic             CAPTURE_CLOCK_POLARITY,   // Capture clock polarity.
  output logic             LOCK,                     // Calibrator in phase.
  output logic [2:0]       DELAY_CODE,               // Delay code as seen by the buffer.
  input  wire logic [3:0]  REG_ADDR,                 // Register address.
  input  wire logic [15:0] REG_WDATA,                // Register write data.
  input  wire logic        REG_WR,                   // Write strobe.
  input  wire logic        REG_RD,                   // Read strobe.
  output logic [15:0]      REG_RDATA                 // Read data, one cycle after the strobe.
);

  // The quarter period in taps, rounded up.
  localparam int TARGET_INT = (`REF_PERIOD_NS / 4 + `TAP_NS - 1) / `TAP_NS;
  localparam ddr_strobe_pkg::delay_code_t TARGET_CODE = 3'(TARGET_INT);

  strobe_link_if link ();

  ddr_strobe_pkg::cal_state_t  state_r;
  ddr_strobe_pkg::cal_state_t  state_nxt;
  ddr_strobe_pkg::delay_code_t track_r;
  ddr_strobe_pkg::delay_code_t code_out_r;
  logic [4:0]                  lock_cnt_r;
  logic                        lock_r;
  logic [3:0]                  ctrl_r;
  logic [2:0]                  err_abs;
  logic [2:0]                  window;
  logic                        in_window;
  logic [7:0]                  span;
  logic [1:0]                  pin_sync_r;

  // Error between the tracking code and the quarter-period target.
  always_comb begin
    err_abs   = (track_r > TARGET_CODE) ? (track_r - TARGET_CODE) : (TARGET_CODE - track_r);
    window    = ctrl_r[`CTRL_SENS_HIGH] ? `SENS_WIN_HIGH : `SENS_WIN_LOW;
    in_window = (err_abs <= window);
  end

  // Next calibrator state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ddr_strobe_pkg::CAL_IDLE: begin
        state_nxt = ddr_strobe_pkg::CAL_TRACK;
      end
      ddr_strobe_pkg::CAL_TRACK: begin
        if (in_window && lock_cnt_r == `LOCK_CYCLES - 5'h01) begin
          state_nxt = ddr_strobe_pkg::CAL_LOCKED;
        end
      end
      ddr_strobe_pkg::CAL_LOCKED: begin
        if (!in_window) begin
          state_nxt = ddr_strobe_pkg::CAL_TRACK;
        end
      end
    endcase
  end

  // Calibrator loop: step the tracking code toward the target and qualify lock.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r    <= ddr_strobe_pkg::CAL_IDLE;
      track_r    <= 3'h0;
      lock_cnt_r <= 5'h00;
      lock_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != ddr_strobe_pkg::CAL_IDLE) begin
        if (track_r < TARGET_CODE) begin
          track_r <= track_r + 3'h1;
        end else if (track_r > TARGET_CODE) begin
          track_r <= track_r - 3'h1;
        end
      end
      if (state_r == ddr_strobe_pkg::CAL_TRACK && in_window) begin
        lock_cnt_r <= lock_cnt_r + 5'h01;
      end else begin
        lock_cnt_r <= 5'h00;
      end
      lock_r <= (state_nxt == ddr_strobe_pkg::CAL_LOCKED);
    end
  end

  // The code sent to the buffer follows the loop only while the update input is low.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      code_out_r <= 3'h0;
    end else if (!DELAY_UPDATE_N) begin
      code_out_r <= track_r;
    end
  end

  assign link.delay_code = code_out_r;
  assign link.lock       = lock_r;
  assign LOCK            = lock_r;
  assign DELAY_CODE      = code_out_r;

  // Strobe buffer; the pin always feeds it, even in general I/O use.
  strobe_delay_buffer u_buffer (
    .clk            (REF_CLK),
    .rst            (RST),
    .strobe_in      (STROBE_I),
    .sys_clk_lvl    (SYS_CLK_LVL),
    .read_pulse     (READ_PULSE),
    .link           (link),
    .strobe_delayed (STROBE_DELAYED),
    .strobe_raw     (STROBE_RAW),
    .preamble_det   (PREAMBLE_DET),
    .polarity       (CAPTURE_CLOCK_POLARITY)
  );

  // Pin input for the general I/O status bit passes two flops.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], STROBE_I};
    end
  end

  // General I/O drive exists only when enabled; in memory use the pin is input only.
  assign STROBE_O  = ctrl_r[`CTRL_GPIO_EN] & ctrl_r[`CTRL_GPIO_OUT];
  assign STROBE_OE = ctrl_r[`CTRL_GPIO_EN] & ctrl_r[`CTRL_GPIO_OE];

  // Group span; the strobe sits at the ninth position in either variant.
  assign span = NARROW_GROUP ? `GROUP_SPAN_NARROW : `GROUP_SPAN_WIDE;

  // Control register write.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_r <= `CTRL_RESET;
    end else if (REG_WR && REG_ADDR == `REG_CTRL) begin
      ctrl_r <= REG_WDATA[3:0];
    end
  end

  // Registered read data, valid only in the cycle after the read strobe.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `REG_CTRL: begin
          REG_RDATA <= {12'h000, ctrl_r};
        end
        `REG_STATUS: begin
          REG_RDATA <= {9'h000, code_out_r, pin_sync_r[1], PREAMBLE_DET,
                        CAPTURE_CLOCK_POLARITY, lock_r};
        end
        `REG_GROUP: begin
          REG_RDATA <= {`STROBE_SLOT, span};
        end
        default: begin
          REG_RDATA <= 16'h0000;
        end
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule

// >>> ddr_strobe_pkg.sv
package ddr_strobe_pkg;

  // Delay code handed from the calibrator to the strobe buffer.
  typedef logic [2:0] delay_code_t;

  // Calibrator states.
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_TRACK,
    CAL_LOCKED
  } cal_state_t;

endpackage

// >>> ddr_strobe_regs.svh
`ifndef DDR_STROBE_REGS_SVH
`define DDR_STROBE_REGS_SVH

// Register offsets on the plain register port.
`define REG_CTRL            4'h0
`define REG_STATUS          4'h1
`define REG_GROUP           4'h2

// Control register fields.
`define CTRL_SENS_HIGH      0
`define CTRL_GPIO_EN        1
`define CTRL_GPIO_OUT       2
`define CTRL_GPIO_OE        3
`define CTRL_RESET          4'h0

// Status register fields.
`define STAT_LOCK           0
`define STAT_POLARITY       1
`define STAT_PREAMBLE       2
`define STAT_PIN_IN         3
`define STAT_CODE_LSB       4

// Group register fields.
`define GROUP_SPAN_LSB      0
`define GROUP_SLOT_LSB      8

// Data and strobe group layout.
`define GROUP_SPAN_WIDE     8'h10
`define GROUP_SPAN_NARROW   8'h0E
`define STROBE_SLOT         8'h08
`define DATA_PER_GROUP      8

// Timing of the calibration loop.
`define REF_PERIOD_NS       100
`define TAP_NS              5
`define DELAY_TAPS          8
`define LOCK_CYCLES         5'h10
`define SENS_WIN_HIGH       3'h0
`define SENS_WIN_LOW        3'h1

`endif

// >>> strobe_cal_chk.sv
`include "ddr_strobe_regs.svh"

module strobe_cal_chk #(
  parameter bit NARROW_GROUP = 1'b0  // Group variant.
) (
  input wire logic        REF_CLK,                 // Clock.
  input wire logic        RST,                     // Reset.
  input wire logic        DELAY_UPDATE_N,          // Update, low.
  input wire logic        READ_PULSE,              // Read pulse.
  input wire logic        SYS_CLK_LVL,             // Clock level.
  input wire logic        STROBE_I,                // Pin in.
  input wire logic        STROBE_O,                // Pin out.
  input wire logic        STROBE_OE,               // Pin enable.
  input wire logic        STROBE_DELAYED,          // Delayed strobe.
  input wire logic        STROBE_RAW,              // Raw strobe.
  input wire logic        PREAMBLE_DET,            // Preamble detect.
  input wire logic        CAPTURE_CLOCK_POLARITY,  // Polarity.
  input wire logic        LOCK,                    // Lock.
  input wire logic [2:0]  DELAY_CODE,              // Code.
  input wire logic [3:0]  REG_ADDR,                // Address.
  input wire logic [15:0] REG_WDATA,               // Write data.
  input wire logic        REG_WR,                  // Write strobe.
  input wire logic        REG_RD,                  // Read strobe.
  input wire logic [15:0] REG_RDATA                // Read data.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] since_r;

  // Counts cycles after reset so that pipelined checks skip the flush.
  always_ff @(posedge REF_CLK) begin
    if (RST) since_r <= 5'h00;
    else if (since_r != 5'h1F) since_r <= since_r + 5'h01;
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_lock_reset: assert property (disable iff (1'b0) RST |=> !LOCK)
    else $error("lock high after reset");
  a_lock_early: assert property ($rose(LOCK) |-> since_r >= 5'h10)
    else $error("lock too early");
  a_lock_bound: assert property (since_r == 5'h1E |-> LOCK)
    else $error("no lock in time");
  a_code_hold: assert property (DELAY_UPDATE_N |=> $stable(DELAY_CODE))
    else $error("code moved while held");
  a_code_locked: assert property (LOCK && !DELAY_UPDATE_N |=> DELAY_CODE == 3'h5)
    else $error("locked code wrong");
  a_raw_path: assert property (since_r >= 5'h03 |-> STROBE_RAW == $past(STROBE_I, 3))
    else $error("raw strobe wrong");
  a_preamble_det: assert property (since_r >= 5'h03 |->
    PREAMBLE_DET == ($past(READ_PULSE) && !$past(STROBE_I, 3)))
    else $error("preamble detect wrong");
  a_pol_moment: assert property (since_r >= 5'h03 && $changed(CAPTURE_CLOCK_POLARITY) |->
    $past(PREAMBLE_DET) && !$past(PREAMBLE_DET, 2))
    else $error("polarity changed off a detect rise");
  a_group_read: assert property ($past(REG_RD) && $past(REG_ADDR) == `REG_GROUP |->
    REG_RDATA == {`STROBE_SLOT, (NARROW_GROUP ? `GROUP_SPAN_NARROW : `GROUP_SPAN_WIDE)})
    else $error("group layout wrong");
  a_oe_cause: assert property ($rose(STROBE_OE) |-> $past(REG_WR) && $past(REG_ADDR) == `REG_CTRL)
    else $error("pin enable without control write");

  c_lock: cover property ($rose(LOCK));
  c_detect: cover property ($rose(PREAMBLE_DET));
  c_polarity: cover property ($rose(CAPTURE_CLOCK_POLARITY));
endmodule

bind ddr_strobe_delay_calibration strobe_cal_chk #(.NARROW_GROUP(NARROW_GROUP)) chk (.REF_CLK, .RST,
  .DELAY_UPDATE_N, .READ_PULSE, .SYS_CLK_LVL, .STROBE_I, .STROBE_O, .STROBE_OE, .STROBE_DELAYED, .STROBE_RAW,
  .PREAMBLE_DET, .CAPTURE_CLOCK_POLARITY, .LOCK, .DELAY_CODE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA);

// >>> strobe_delay_buffer.sv
`include "ddr_strobe_regs.svh"

module strobe_delay_buffer (
  input  wire logic  clk,            // Reference clock.
  input  wire logic  rst,            // Synchronous reset, active high.
  input  wire logic  strobe_in,      // Strobe from the memory pin.
  input  wire logic  sys_clk_lvl,    // Fabric system clock level.
  input  wire logic  read_pulse,     // Read pulse from the fabric.
  strobe_link_if.dst link,           // Delay code from the calibrator.
  output logic       strobe_delayed, // Delayed strobe to the capture registers.
  output logic       strobe_raw,     // Undelayed strobe to the fabric.
  output logic       preamble_det,   // Preamble detect to the fabric.
  output logic       polarity        // Capture clock polarity.
);

  logic [1:0]              strobe_sync_r;
  logic [1:0]              sclk_sync_r;
  logic [`DELAY_TAPS-1:0]  line_r;
  logic                    read_d_r;
  logic                    armed_r;
  logic                    prm_d_r;

  // Two flops on the pin inputs; only the second stage is read.
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_sync_r <= 2'h0;
      sclk_sync_r   <= 2'h0;
    end else begin
      strobe_sync_r <= {strobe_sync_r[0], strobe_in};
      sclk_sync_r   <= {sclk_sync_r[0], sys_clk_lvl};
    end
  end

  // Tapped delay line; the tap is chosen by the calibrated code.
  always_ff @(posedge clk) begin
    if (rst) begin
      line_r         <= '0;
      strobe_delayed <= 1'b0;
      strobe_raw     <= 1'b0;
    end else begin
      line_r         <= {line_r[`DELAY_TAPS-2:0], strobe_sync_r[1]};
      strobe_delayed <= line_r[link.delay_code];
      strobe_raw     <= strobe_sync_r[1];
    end
  end

  // A read rising edge arms detection; the first low strobe seen then is the preamble.
  always_ff @(posedge clk) begin
    if (rst) begin
      read_d_r     <= 1'b0;
      armed_r      <= 1'b0;
      preamble_det <= 1'b0;
      prm_d_r      <= 1'b0;
      polarity     <= 1'b0;
    end else begin
      read_d_r     <= read_pulse;
      prm_d_r      <= preamble_det;
      preamble_det <= read_pulse & ~strobe_sync_r[1];
      if (read_pulse & ~read_d_r) begin
        armed_r <= 1'b1;
      end else if (preamble_det & ~prm_d_r) begin
        armed_r <= 1'b0;
      end
      // Clock level at the first detect edge picks the polarity.
      if (armed_r & preamble_det & ~prm_d_r) begin
        polarity <= sclk_sync_r[1];
      end
    end
  end

endmodule

// >>> strobe_link_if.sv
interface strobe_link_if;
  ddr_strobe_pkg::delay_code_t delay_code;
  logic                        lock;

  modport src (output delay_code, output lock);
  modport dst (input delay_code, input lock);
endinterface

// >>> tb.sv
`include "ddr_strobe_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        DELAY_UPDATE_N = 1'b1;
  logic        READ_PULSE = 1'b0;
  logic        SYS_CLK_LVL = 1'b0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic        STROBE_I, STROBE_O, STROBE_OE, STROBE_DELAYED, STROBE_RAW, PREAMBLE_DET, CAPTURE_CLOCK_POLARITY, LOCK;
  logic [2:0]  DELAY_CODE;
  logic [15:0] REG_RDATA;
  logic [15:0] rd;
  logic        raw_q = 1'b0;
  logic        dly_q = 1'b0;
  int          fail_count = 0;
  int          comparisons = 0;
  int          raw_rises = 0;
  int          dly_rises = 0;
  int          t_high;
  int          t_low;

  // Half period of 50 ns gives the 10 MHz reference.
  always #50 REF_CLK = ~REF_CLK;

  ddr_strobe_delay_calibration dut (.REF_CLK, .RST, .DELAY_UPDATE_N, .READ_PULSE, .SYS_CLK_LVL, .STROBE_I,
    .STROBE_O, .STROBE_OE, .STROBE_DELAYED, .STROBE_RAW, .PREAMBLE_DET, .CAPTURE_CLOCK_POLARITY, .LOCK,
    .DELAY_CODE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA);
  ddr_mem_model mem (.clk(REF_CLK), .strobe(STROBE_I));

  // Tallies rises of both strobe outputs for the burst checks.
  always @(posedge REF_CLK) begin
    raw_q <= STROBE_RAW;
    dly_q <= STROBE_DELAYED;
    raw_rises <= raw_rises + int'(STROBE_RAW && !raw_q);
    dly_rises <= dly_rises + int'(STROBE_DELAYED && !dly_q);
  end

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    @(posedge REF_CLK);
    d = REG_RDATA;
  endtask

  // Resets, sets the lock sensitivity and times the lock in cycles after release.
  task automatic lock_run(input logic sens, input logic upd, output int t);
    DELAY_UPDATE_N <= upd;
    RST <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    check({15'h0000, LOCK}, 16'h0000);
    t = sens ? 2 : 0;
    if (sens) reg_wr(`REG_CTRL, 16'h0001);
    while (LOCK !== 1'b1 && t < 60) begin
      @(posedge REF_CLK);
      t++;
    end
  endtask

  // One read: the pulse falls inside the preamble, then rises are counted once it has flushed.
  task automatic read_burst(input logic lvl);
    int r0;
    int d0;
    SYS_CLK_LVL <= lvl;
    DELAY_UPDATE_N <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    READ_PULSE <= 1'b1;
    fork
      mem.burst(16, 8);
      begin
        repeat (6) @(posedge REF_CLK);
        READ_PULSE <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        r0 = raw_rises;
        d0 = dly_rises;
      end
    join
    check(16'(raw_rises - r0), 16'h0004);
    check(16'(dly_rises - d0), 16'h0004);
    check({15'h0000, CAPTURE_CLOCK_POLARITY}, {15'h0000, lvl});
  endtask

  // Main sequence: lock in both modes, registers and pin, then two reads.
  initial begin
    lock_run(1'b1, 1'b1, t_high);
    check({15'h0000, LOCK}, 16'h0001);
    check({13'h0000, DELAY_CODE}, 16'h0000);
    DELAY_UPDATE_N <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    check({13'h0000, DELAY_CODE}, 16'h0005);
    reg_rd(`REG_STATUS, rd);
    check(rd & 16'h0071, 16'h0051);
    lock_run(1'b0, 1'b0, t_low);
    check(16'(t_low < t_high), 16'h0001);
    reg_rd(`REG_GROUP, rd);
    check(rd, 16'h0810);
    reg_wr(`REG_CTRL, 16'h000E);
    reg_wr(4'hF, 16'h0000);
    check({14'h0000, STROBE_O, STROBE_OE}, 16'h0003);
    reg_rd(4'hF, rd);
    check(rd, 16'h0000);
    reg_rd(`REG_CTRL, rd);
    check(rd, 16'h000E);
    reg_wr(`REG_CTRL, 16'h0000);
    check({14'h0000, STROBE_O, STROBE_OE}, 16'h0000);
    read_burst(1'b1);
    read_burst(1'b0);
    stop_test();
  end

  // Cuts a hang short well past the expected hundred and fifty or so cycles.
  initial begin
    repeat (2000) @(posedge REF_CLK);
    fail_count++;
    stop_test();
  end
endmodule
